// ==== sio_consts.svh ====
// offsets, fields, resets and timing
`ifndef SIO_CONSTS_SVH
`define SIO_CONSTS_SVH

// device byte addresses, low byte
`define SIO_ADDR_ALARM 7'h2E
`define SIO_ADDR_AUX 7'h30
`define SIO_ADDR_GPCFG 7'h32
`define SIO_ADDR_MISC 7'h34
`define SIO_ADDR_SMPL 7'h36
`define SIO_ADDR_DIAG 7'h3C
`define SIO_ADDR_GLOB 7'h3E

// reset values and write masks
`define SIO_MISC_RESET 16'h0006
`define SIO_SMPL_RESET 16'h0001
`define SIO_MISC_LO_MASK 8'hC7
`define SIO_MISC_HI_MASK 8'h0F

// field positions
`define SIO_MISC_DR_LINE 0
`define SIO_MISC_DR_POL 1
`define SIO_MISC_DR_EN 2
`define SIO_MISC_ALIGN 6
`define SIO_MISC_COMP 7
`define SIO_MISC_STIM_POS 8
`define SIO_MISC_STIM_NEG 9
`define SIO_MISC_SELFTEST 10
`define SIO_MISC_MEMTEST 11
`define SIO_GLOB_DAC_LATCH 2
`define SIO_DIAG_ST_ERR 5
`define SIO_DIAG_FLASH 6
`define SIO_GPCFG_LINE4_DIR 3

// data-ready pulse midway in its window
`define SIO_CLK_NS 50
`define SIO_DR_MIN_NS 100000
`define SIO_DR_MAX_NS 200000
`define SIO_DR_CYCLES ((`SIO_DR_MIN_NS + `SIO_DR_MAX_NS) / 2 / `SIO_CLK_NS)
`define SIO_HALF_CYCLES 8

// controller register offsets
`define SIO_CTL_CMD 8'h00
`define SIO_CTL_STATUS 8'h04
`define SIO_CTL_RDATA 8'h08
`define SIO_RESP_OKAY 2'b00
`define SIO_RESP_SLVERR 2'b10

`endif

// ==== sio_pkg.sv ====
// state types of both link ends
package sio_pkg;

    typedef enum logic [1:0] {
        st_idle = 2'b01,
        st_run = 2'b10
    } sio_host_state_t;

    typedef struct packed {
        logic sclk_q;
        logic cs_q;
        logic line4_q;
        logic [4:0] bitcnt;
        logic [15:0] rx;
        logic [15:0] tx;
        logic [15:0] resp;
        logic miso;
        logic miso_oe;
        logic [15:0] gp_cfg;
        logic [15:0] misc;
        logic [15:0] alarm;
        logic [15:0] smpl;
        logic [15:0] aux;
        logic [15:0] diag;
        logic [11:0] dac;
        logic [11:0] dr_cnt;
        logic st_busy;
        logic mt_busy;
        logic st_start;
        logic mt_start;
        logic ext_mode;
        logic [3:0] gp_o;
        logic [3:0] gp_oe;
    } sio_dev_t;

    typedef struct packed {
        sio_host_state_t state;
        logic [5:0] hcnt;
        logic [7:0] div;
        logic frame;
        logic wr;
        logic [6:0] addr;
        logic [15:0] data;
        logic [15:0] tx;
        logic [15:0] rx;
        logic [15:0] rdata;
        logic done;
        logic sclk;
        logic cs_n;
        logic mosi;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata_bus;
    } sio_host_t;

endpackage

// ==== sio_link_if.sv ====
// serial link between the two ends
`timescale 1ns/1ns
`default_nettype none

interface sio_link_if;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic miso;
    logic miso_oe;
    logic miso_line;

    // released line idles high
    assign miso_line = miso_oe ? miso : 1'b1;

    modport dev (input sclk, input cs_n, input mosi, output miso, output miso_oe);
    modport host (output sclk, output cs_n, output mosi, input miso_line);
endinterface

`default_nettype wire

// ==== sio_sync.sv ====
// two-flop synchroniser
`timescale 1ns/1ns
`default_nettype none

module sio_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // async in, synchronised out
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            meta <= RESET_VAL;
            dout <= RESET_VAL;
        end
        else
        begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule // sio_sync

`default_nettype wire

// ==== sio_device.sv ====
// sensor end: io lines, data ready, converter, self-test
// How it works
// - line owner: misc, then alarm, then gpio
// - gpio config bits 3:0 set direction
// - bits 11:8 drive outputs, read output level or input pin
// - line4 input and zero period: external clock
// - reset: data ready on line1, active high
// - misc 2:0 enable, polarity, line of ready
// - data ready pulse 100 to 200 us
// - misc bit11 starts memory test, self-clears
// - misc bit10 runs self-test, posts, self-clears
// - misc bits 9,8 hold negative/positive stimulus
// - misc bit7 enables gyro acceleration compensation
// - misc bit6 enables accelerometer origin alignment
// - aux converter holds 12-bit offset binary
// - latch command copies aux to converter
// - host writes upper byte word first
// - read word, contents on next transfer
// - host waits between stimulus changes, clears
// - per-axis self-test fails, overall bit 5
// - diagnostic flags clear on read
// - command bits return to zero when done
`timescale 1ns/1ns
`default_nettype none
`include "sio_consts.svh"

module sio_device #(
    parameter int DR_CYCLES = `SIO_DR_CYCLES
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // serial link
    sio_link_if.dev link,
    // general-purpose lines
    input wire logic [3:0] gp_line_i,
    output logic [3:0] gp_line_o,
    output logic [3:0] gp_line_oe,
    // sampling and alarm
    input wire logic sample_tick,
    input wire logic alarm_active,
    output logic ext_clock_mode,
    // self-test and memory test engines
    output logic self_test_start,
    input wire logic self_test_done,
    input wire logic [5:0] self_test_fail,
    output logic mem_test_start,
    input wire logic mem_test_done,
    input wire logic mem_test_fail,
    output logic stim_neg,
    output logic stim_pos,
    // sensor compensation and converter
    output logic gyro_accel_comp_en,
    output logic accel_align_en,
    output logic [11:0] dac_value
);
    import sio_pkg::*;

    sio_dev_t s;
    sio_dev_t next_s;
    logic [6:0] sy;

    ////////////////////////////////////////////////////////////////////////////////
    // pins cross into aclk; sclk, cs reset to idle
    sio_sync #(
        .WIDTH(7),
        .RESET_VAL(7'h03)
    ) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .din({gp_line_i, link.mosi, link.cs_n, link.sclk}),
        .dout(sy)
    );

    ////////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        logic rise;
        logic fall;
        logic cs_fall;
        logic cs_rise;
        logic [7:0] d;
        logic [6:0] wa;
        logic [3:0] pin;
        logic [3:0] rd_lvl;
        logic [3:0] owned;
        logic dr_lvl;
        logic al_lvl;
        logic smp;
        rise = sy[0] && !s.sclk_q;
        fall = !sy[0] && s.sclk_q;
        cs_fall = !sy[1] && s.cs_q;
        cs_rise = sy[1] && !s.cs_q;
        d = s.rx[7:0];
        wa = {s.rx[14:9], 1'b0};
        pin = sy[6:3];
        owned = '0;
        rd_lvl = '0;
        dr_lvl = 1'b0;
        al_lvl = 1'b0;
        smp = 1'b0;
        next_s = s;
        next_s.sclk_q = sy[0];
        next_s.cs_q = sy[1];
        next_s.line4_q = sy[6];
        next_s.st_start = 1'b0;
        next_s.mt_start = 1'b0;

        // serial shift
        if (cs_fall)
        begin
            next_s.tx = s.resp;
            next_s.miso = s.resp[15];
            next_s.bitcnt = '0;
        end
        else if (!sy[1] && rise)
        begin
            next_s.rx = {s.rx[14:0], sy[2]};
            next_s.bitcnt = s.bitcnt + 5'd1;
        end
        else if (!sy[1] && fall && s.bitcnt != 5'd0)
        begin
            next_s.tx = {s.tx[14:0], 1'b0};
            next_s.miso = s.tx[14];
        end
        next_s.miso_oe = !sy[1];

        // read level; lines set as output report bits 11:8, others pin
        for (int i = 0; i < 4; i++)
        begin
            rd_lvl[i] = (s.gp_cfg[i] && !s.gp_oe[i]) ? pin[i] : (s.gp_cfg[i] ? s.gp_cfg[8+i] : pin[i]);
        end

        // decode full frames
        if (cs_rise && s.bitcnt == 5'd16)
        begin
            if (s.rx[15])
            begin
                unique case (wa)
                    `SIO_ADDR_AUX:
                    begin
                        if (s.rx[8])
                            next_s.aux[15:8] = {4'h0, d[3:0]};
                        else
                            next_s.aux[7:0] = d;
                    end
                    `SIO_ADDR_GPCFG:
                    begin
                        if (s.rx[8])
                            next_s.gp_cfg[15:8] = {4'h0, d[3:0]};
                        else
                            next_s.gp_cfg[7:0] = {4'h0, d[3:0]};
                    end
                    `SIO_ADDR_MISC:
                    begin
                        if (s.rx[8])
                        begin
                            next_s.misc[15:8] = d & `SIO_MISC_HI_MASK;
                            if (d[3] && !s.mt_busy)
                            begin
                                next_s.mt_start = 1'b1;
                                next_s.mt_busy = 1'b1;
                            end
                            if (d[2] && !s.st_busy)
                            begin
                                next_s.st_start = 1'b1;
                                next_s.st_busy = 1'b1;
                            end
                        end
                        else
                            next_s.misc[7:0] = d & `SIO_MISC_LO_MASK;
                    end
                    `SIO_ADDR_SMPL:
                    begin
                        if (!s.rx[8])
                            next_s.smpl[7:0] = d;
                    end
                    `SIO_ADDR_ALARM:
                    begin
                        if (s.rx[8])
                            next_s.alarm[15:8] = d;
                        else
                            next_s.alarm[7:0] = d;
                    end
                    `SIO_ADDR_GLOB:
                    begin
                        if (!s.rx[8] && d[`SIO_GLOB_DAC_LATCH])
                            next_s.dac = s.aux[11:0];
                    end
                    default:
                    begin
                    end
                endcase
            end
            else
            begin
                unique case (wa)
                    `SIO_ADDR_AUX: next_s.resp = s.aux;
                    `SIO_ADDR_GPCFG: next_s.resp = {4'h0, rd_lvl, 4'h0, s.gp_cfg[3:0]};
                    `SIO_ADDR_MISC: next_s.resp = s.misc;
                    `SIO_ADDR_SMPL: next_s.resp = s.smpl;
                    `SIO_ADDR_ALARM: next_s.resp = s.alarm;
                    `SIO_ADDR_DIAG:
                    begin
                        next_s.resp = s.diag;
                        next_s.diag = '0;
                    end
                    default: next_s.resp = 16'h0000;
                endcase
            end
        end

        // set wins over read clear
        if (s.st_busy && self_test_done)
        begin
            next_s.st_busy = 1'b0;
            next_s.misc[`SIO_MISC_SELFTEST] = 1'b0;
            next_s.diag[15:10] = next_s.diag[15:10] | self_test_fail;
            next_s.diag[`SIO_DIAG_ST_ERR] = next_s.diag[`SIO_DIAG_ST_ERR] | (|self_test_fail);
        end
        if (s.mt_busy && mem_test_done)
        begin
            next_s.mt_busy = 1'b0;
            next_s.misc[`SIO_MISC_MEMTEST] = 1'b0;
            next_s.diag[`SIO_DIAG_FLASH] = next_s.diag[`SIO_DIAG_FLASH] | mem_test_fail;
        end

        // sample pacing, data ready
        next_s.ext_mode = !s.gp_cfg[`SIO_GPCFG_LINE4_DIR] && s.smpl[6:0] == 7'h00;
        smp = s.ext_mode ? (sy[6] && !s.line4_q) : sample_tick;
        if (smp)
            next_s.dr_cnt = 12'(DR_CYCLES);
        else if (s.dr_cnt != 12'h000)
            next_s.dr_cnt = s.dr_cnt - 12'h001;
        dr_lvl = (s.dr_cnt != 12'h000) == s.misc[`SIO_MISC_DR_POL];
        al_lvl = alarm_active == s.alarm[1];

        // line ownership by priority
        for (int i = 0; i < 4; i++)
        begin
            if (s.misc[`SIO_MISC_DR_EN] && i == int'(s.misc[`SIO_MISC_DR_LINE]))
            begin
                owned[i] = 1'b1;
                next_s.gp_oe[i] = 1'b1;
                next_s.gp_o[i] = dr_lvl;
            end
            else if (s.alarm[2] && i == int'(s.alarm[0]))
            begin
                owned[i] = 1'b1;
                next_s.gp_oe[i] = 1'b1;
                next_s.gp_o[i] = al_lvl;
            end
            else
            begin
                next_s.gp_oe[i] = s.gp_cfg[i];
                next_s.gp_o[i] = s.gp_cfg[8+i];
            end
            if (owned[i])
                next_s.gp_oe[i] = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s <= '0;
            s.sclk_q <= 1'b1;
            s.cs_q <= 1'b1;
            s.misc <= `SIO_MISC_RESET;
            s.smpl <= `SIO_SMPL_RESET;
        end
        else
            s <= next_s;
    end

    assign link.miso = s.miso;
    assign link.miso_oe = s.miso_oe;
    assign gp_line_o = s.gp_o;
    assign gp_line_oe = s.gp_oe;
    assign ext_clock_mode = s.ext_mode;
    assign self_test_start = s.st_start;
    assign mem_test_start = s.mt_start;
    assign stim_neg = s.misc[`SIO_MISC_STIM_NEG];
    assign stim_pos = s.misc[`SIO_MISC_STIM_POS];
    assign gyro_accel_comp_en = s.misc[`SIO_MISC_COMP];
    assign accel_align_en = s.misc[`SIO_MISC_ALIGN];
    assign dac_value = s.dac;
endmodule // sio_device

`default_nettype wire

// ==== sio_host.sv ====
// controller end: axi4-lite orders to serial frames
`timescale 1ns/1ns
`default_nettype none
`include "sio_consts.svh"

module sio_host #(
    parameter int HALF = `SIO_HALF_CYCLES
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // serial link
    sio_link_if.host link
);
    import sio_pkg::*;

    sio_host_t s;
    sio_host_t next_s;
    logic miso_s;

    sio_sync #(
        .WIDTH(1)
    ) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .din(link.miso_line),
        .dout(miso_s)
    );

    ////////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        logic [15:0] word;
        word = 16'h0000;
        next_s = s;
        next_s.awready = 1'b0;
        next_s.wready = 1'b0;
        next_s.arready = 1'b0;
        // upper byte first; read data on second frame
        if (s.wr)
            word = s.frame ? {1'b1, s.addr[6:1], 1'b0, s.data[7:0]} : {1'b1, s.addr[6:1], 1'b1, s.data[15:8]};
        else
            word = s.frame ? 16'h0000 : {1'b0, s.addr[6:1], 1'b0, 8'h00};

        // write channel
        if (s.bvalid && s_axi_bready)
            next_s.bvalid = 1'b0;
        if (s_axi_awvalid && s_axi_wvalid && !s.awready && !s.bvalid)
        begin
            next_s.awready = 1'b1;
            next_s.wready = 1'b1;
            next_s.bvalid = 1'b1;
            next_s.bresp = `SIO_RESP_SLVERR;
            if (s_axi_awaddr == `SIO_CTL_CMD && s.state == st_idle && s_axi_wstrb != 4'h0)
            begin
                next_s.bresp = `SIO_RESP_OKAY;
                next_s.state = st_run;
                next_s.wr = s_axi_wdata[31];
                next_s.addr = s_axi_wdata[22:16];
                next_s.data = s_axi_wdata[15:0];
                next_s.frame = 1'b0;
                next_s.hcnt = '0;
                next_s.div = 8'(HALF - 1);
                next_s.done = 1'b0;
            end
        end

        // read channel
        if (s.rvalid && s_axi_rready)
            next_s.rvalid = 1'b0;
        if (s_axi_arvalid && !s.arready && !s.rvalid)
        begin
            next_s.arready = 1'b1;
            next_s.rvalid = 1'b1;
            unique case (s_axi_araddr)
                `SIO_CTL_STATUS: next_s.rdata_bus = {30'h0, s.done, s.state == st_run};
                `SIO_CTL_RDATA: next_s.rdata_bus = {16'h0000, s.rdata};
                default: next_s.rdata_bus = 32'h0000_0000;
            endcase
        end

        // one frame step per half period
        if (s.state == st_run)
        begin
            if (s.div != 8'h00)
                next_s.div = s.div - 8'h01;
            else
            begin
                next_s.div = 8'(HALF - 1);
                next_s.hcnt = s.hcnt + 6'd1;
                if (s.hcnt == 6'd0)
                begin
                    next_s.cs_n = 1'b0;
                    next_s.tx = word;
                end
                else if (s.hcnt <= 6'd32 && s.hcnt[0])
                begin
                    next_s.sclk = 1'b0;
                    next_s.mosi = s.tx[15];
                    next_s.tx = {s.tx[14:0], 1'b0};
                end
                else if (s.hcnt <= 6'd32)
                begin
                    next_s.sclk = 1'b1;
                    next_s.rx = {s.rx[14:0], miso_s};
                end
                else if (s.hcnt == 6'd33)
                    next_s.cs_n = 1'b1;
                else if (s.hcnt == 6'd35)
                begin
                    next_s.hcnt = '0;
                    next_s.frame = 1'b1;
                    if (s.frame)
                    begin
                        next_s.state = st_idle;
                        next_s.done = 1'b1;
                        if (!s.wr)
                            next_s.rdata = s.rx;
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s <= '0;
            s.state <= st_idle;
            s.sclk <= 1'b1;
            s.cs_n <= 1'b1;
        end
        else
            s <= next_s;
    end

    assign link.sclk = s.sclk;
    assign link.cs_n = s.cs_n;
    assign link.mosi = s.mosi;
    assign s_axi_awready = s.awready;
    assign s_axi_wready = s.wready;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_arready = s.arready;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rresp = `SIO_RESP_OKAY;
    assign s_axi_rdata = s.rdata_bus;
endmodule // sio_host

`default_nettype wire

// ==== sio_link_assertions.sv ====
// checker of link framing and device outputs
`timescale 1ns/1ns
`default_nettype none

module sio_link_assertions #(
    parameter int DR_CYCLES = 20
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // link
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic miso_oe,
    // device outputs
    input wire logic [3:0] gp_line_o,
    input wire logic [3:0] gp_line_oe,
    input wire logic [11:0] dac_value,
    input wire logic stim_neg,
    input wire logic stim_pos,
    input wire logic gyro_accel_comp_en,
    input wire logic accel_align_en,
    input wire logic self_test_start,
    input wire logic mem_test_start
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [4:0] n_fall;
    logic [15:0] hi_cnt;
    ////////////////////////////////////////////////////////////////
    // sclk falls per frame, line 1 high run
    always_ff @(posedge aclk)
    begin
        if (!aresetn || cs_n)
            n_fall <= 5'h00;
        else if ($fell(sclk))
            n_fall <= n_fall + 5'h01;
        if (!aresetn || !gp_line_o[0])
            hi_cnt <= 16'h0000;
        else
            hi_cnt <= hi_cnt + 16'h0001;
    end
    ////////////////////////////////////////////////////////////////
    sequence s_idle5;
        cs_n [*5];
    endsequence
    sequence s_frame_end;
        $rose(cs_n);
    endsequence
    a_sclk_idle: assert property (cs_n |-> sclk)
        else $error("sclk low outside frame");
    a_frame_bits: assert property (s_frame_end |-> n_fall == 5'h10)
        else $error("frame not 16 bits");
    a_mosi_hold: assert property ((!cs_n && !$past(cs_n) && sclk && $past(sclk)) |-> $stable(mosi))
        else $error("mosi moved with sclk high");
    a_miso_release: assert property (s_idle5 |-> !miso_oe)
        else $error("miso driven outside frame");
    a_dac_hold: assert property (!cs_n |=> $stable(dac_value))
        else $error("dac moved in frame");
    a_ctrl_hold: assert property (!cs_n |=> $stable({stim_neg, stim_pos, gyro_accel_comp_en, accel_align_en}))
        else $error("control moved in frame");
    a_start_pulse: assert property ((self_test_start || mem_test_start) |=> !(self_test_start || mem_test_start))
        else $error("start not one cycle");
    a_ready_width: assert property (($fell(gp_line_o[0]) && gp_line_oe[0])
        |-> hi_cnt inside {[DR_CYCLES - 1:DR_CYCLES + 1]})
        else $error("data ready width");
    a_ready_default: assert property ($rose(aresetn) |-> ##2 gp_line_oe[0])
        else $error("line 1 not driven after reset");
endmodule // sio_link_assertions

`default_nettype wire

// ==== test_sensor_io_and_selftest_control.sv ====
// bench of both ends across the link
`timescale 1ns/1ns
`default_nettype none
`include "sio_consts.svh"

module test_sensor_io_and_selftest_control;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, s, rnd = 32'hCAC2;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, ext, st_start, mt_start, sneg, spos, comp, align;
    logic [1:0] bresp, r;
    logic [3:0] gpi = 4'h0, gpo, gpoe;
    logic tick = 1'b0, alarm = 1'b0, st_done = 1'b0, mt_done = 1'b0;
    logic [11:0] dac, v = 12'h000;
    logic [15:0] q[$];
    int n_mismatch = 0, total_checks = 0;
    sio_link_if link_if();
    sio_device #(.DR_CYCLES(20)) sio_device_inst (.aclk(aclk), .aresetn(aresetn), .link(link_if),
        .gp_line_i(gpi), .gp_line_o(gpo), .gp_line_oe(gpoe), .sample_tick(tick), .alarm_active(alarm),
        .ext_clock_mode(ext), .self_test_start(st_start), .self_test_done(st_done), .self_test_fail(6'h05),
        .mem_test_start(mt_start), .mem_test_done(mt_done), .mem_test_fail(1'b1), .stim_neg(sneg),
        .stim_pos(spos), .gyro_accel_comp_en(comp), .accel_align_en(align), .dac_value(dac));
    sio_host sio_host_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .link(link_if));
    sio_link_assertions #(.DR_CYCLES(20)) sio_link_assertions_inst (.aclk(aclk), .aresetn(aresetn),
        .sclk(link_if.sclk), .cs_n(link_if.cs_n), .mosi(link_if.mosi), .miso_oe(link_if.miso_oe),
        .gp_line_o(gpo), .gp_line_oe(gpoe), .dac_value(dac), .stim_neg(sneg), .stim_pos(spos),
        .gyro_accel_comp_en(comp), .accel_align_en(align), .self_test_start(st_start),
        .mem_test_start(mt_start));
    initial forever #25 aclk = ~aclk;
    // test engines answer one cycle after start
    always @(posedge aclk)
    begin
        st_done <= st_start;
        mt_done <= mt_start;
    end
    always @(posedge aclk)
        if (rvalid && rready && q.size() > 0)
            cmp("rdata", q.pop_front(), rdata[15:0]);
    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
            if (bvalid)
            begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (arready)
                arvalid <= 1'b0;
            if (rvalid)
            begin
                s = rdata;
                rready <= 1'b0;
                break;
            end
        end
    endtask
    task automatic op(input logic w, input logic [6:0] a, input logic [15:0] d);
        wr(`SIO_CTL_CMD, {w, 8'h00, a, d});
        s = 32'h0;
        while (s[1] !== 1'b1)
            rd(`SIO_CTL_STATUS);
        repeat (4) @(posedge aclk);
    endtask
    task automatic chk(input logic [6:0] a, input logic [15:0] e);
        op(1'b0, a, 16'h0000);
        q.push_back(e);
        rd(`SIO_CTL_RDATA);
    endtask
    task automatic summarize();
        if (n_mismatch == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (80000) @(posedge aclk);
        n_mismatch++;
        summarize();
    end
    initial
    begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        cmp("oe", 16'h0001, {15'h0000, gpoe[0]});
        chk(`SIO_ADDR_MISC, `SIO_MISC_RESET);
        gpi <= rnd[3:0];
        op(1'b1, `SIO_ADDR_GPCFG, 16'h080C);
        cmp("gp34", 16'h000E, {12'h000, gpoe[3:2], gpo[3:2]});
        chk(`SIO_ADDR_GPCFG, {6'h02, rnd[1:0], 8'h0C});
        op(1'b1, `SIO_ADDR_GPCFG, 16'h0003);
        alarm <= 1'b1;
        op(1'b1, `SIO_ADDR_ALARM, 16'h0007);
        cmp("prio", 16'h0003, {14'h0000, gpo[1], gpoe[0]});
        op(1'b1, `SIO_ADDR_MISC, 16'h0007);
        cmp("line2", 16'h0000, {15'h0000, gpo[1]});
        op(1'b1, `SIO_ADDR_MISC, 16'h0005);
        cmp("pol", 16'h0001, {15'h0000, gpo[1]});
        alarm <= 1'b0;
        op(1'b1, `SIO_ADDR_MISC, 16'h0006);
        op(1'b1, `SIO_ADDR_SMPL, 16'h0000);
        cmp("ext", 16'h0001, {15'h0000, ext});
        op(1'b1, `SIO_ADDR_SMPL, 16'h0001);
        cmp("ext", 16'h0000, {15'h0000, ext});
        tick <= 1'b1;
        @(posedge aclk);
        tick <= 1'b0;
        repeat (6) @(posedge aclk);
        cmp("ready", 16'h0001, {15'h0000, gpo[0]});
        repeat (30) @(posedge aclk);
        for (int i = 0; i < 2; i++)
        begin
            rnd = lfsr(rnd);
            op(1'b1, `SIO_ADDR_AUX, {4'h0, rnd[11:0]});
            cmp("dac", {4'h0, v}, {4'h0, dac});
            v = rnd[11:0];
            op(1'b1, `SIO_ADDR_GLOB, 16'h0004);
            cmp("dac", {4'h0, v}, {4'h0, dac});
        end
        chk(`SIO_ADDR_AUX, {4'h0, v});
        chk(`SIO_ADDR_GLOB, 16'h0000);
        op(1'b1, `SIO_ADDR_MISC, 16'h0406);
        chk(`SIO_ADDR_MISC, 16'h0006);
        chk(`SIO_ADDR_DIAG, 16'h1420);
        chk(`SIO_ADDR_DIAG, 16'h0000);
        op(1'b1, `SIO_ADDR_MISC, 16'h0806);
        chk(`SIO_ADDR_MISC, 16'h0006);
        chk(`SIO_ADDR_DIAG, 16'h0040);
        op(1'b1, `SIO_ADDR_MISC, 16'h03C6);
        cmp("ctl", 16'h000F, {12'h000, sneg, spos, comp, align});
        chk(`SIO_ADDR_MISC, 16'h03C6);
        op(1'b1, `SIO_ADDR_MISC, 16'h0006);
        cmp("ctl", 16'h0000, {12'h000, sneg, spos, comp, align});
        chk(7'h50, 16'h0000);
        wr(8'h0C, 32'h0);
        cmp("bresp", {14'h0000, `SIO_RESP_SLVERR}, {14'h0000, r});
        summarize();
    end
endmodule // test_sensor_io_and_selftest_control

`default_nettype wire
